//--- logic/spfu_params.svh
/*
 * Timing counts, field positions and the exponent bias of the single precision float unit.
 * Assumes a 100 MHz core clock and 32-bit operands of sign, 8-bit exponent, 23-bit fraction.
 */
// Functional notes
// - A bus request with more than 8 us still to run aborts the instruction.
// - After an abort the program counter still addresses the aborted instruction.
// - Floating work never delays direct memory transfer requests.
// - Interrupt requests are granted only at instruction boundaries.
// - Exactly four operations: add, subtract, multiply, divide.
// - Words hold sign, exponent and fraction; binary point left of fraction top.
// - Normalize by shifting left until top bit is one, exponent minus one each.
// - Add and subtract shift the smaller-exponent fraction right until exponents match.
// - Multiply multiplies fractions and adds exponents.
// - Divide divides fractions and subtracts exponents.
// - Exponents are biased by octal 200, covering -128 to +127.
// - Fractions are sign-magnitude, never two's complement.
// - Every result rounds away from zero.
// - An operand with zero exponent is zero whatever its other bits.
// - A zero result is a word of 32 cleared bits.
// - Time is a base per operation plus per-shift alignment and normalization costs.
`ifndef SPFU_PARAMS_SVH
`define SPFU_PARAMS_SVH
`define SPFU_CLK_NS      10
`define SPFU_T_ADD_NS    18780
`define SPFU_T_SUB_NS    19080
`define SPFU_T_MUL_NS    29000
`define SPFU_T_DIV_NS    46270
`define SPFU_T_ALIGN_NS  300
`define SPFU_T_NORM_NS   340
`define SPFU_T_ABORT_NS  8000
`define SPFU_CYC_UP(ns)  (((ns) + `SPFU_CLK_NS - 1) / `SPFU_CLK_NS)
`define SPFU_CYC_DN(ns)  ((ns) / `SPFU_CLK_NS)
`define SPFU_SIGN_BIT    31
`define SPFU_EXP_HI      30
`define SPFU_EXP_LO      23
`define SPFU_EXP_BIAS    11'sh080
`define SPFU_EXP_MAX     11'sh0ff
`define SPFU_DIV_STEPS   5'h1b
`define SPFU_PC_STEP     16'h0002
`endif

//--- logic/spfu_pkg.sv
/*
 * Types of the single precision float unit: operations, states, request and answer.
 * Assumes the host fetches both operands before it raises a request.
 */
`default_nettype none
package spfu_pkg;
    typedef enum logic [1:0] {
        float_add_op      = 2'h0,
        float_subtract_op = 2'h1,
        float_multiply_op = 2'h2,
        float_divide_op   = 2'h3
    } spfu_op_t;

    typedef enum logic [6:0] {
        st_idle  = 7'h01,
        st_align = 7'h02,
        st_comb  = 7'h04,
        st_div   = 7'h08,
        st_norm  = 7'h10,
        st_rnd   = 7'h20,
        st_pad   = 7'h40
    } spfu_state_t;

    typedef struct packed {
        spfu_op_t    op;
        logic [15:0] pc;
        logic [31:0] a;
        logic [31:0] b;
    } spfu_req_t;

    typedef struct packed {
        logic [31:0] word;
        logic        ovf;
        logic        unf;
        logic        dvz;
    } spfu_rsp_t;

    typedef struct packed {
        spfu_state_t        st;
        spfu_op_t           op;
        logic [15:0]        pc;
        logic               sa;
        logic               sb;
        logic               dz;
        logic [7:0]         ea;
        logic [7:0]         eb;
        logic [26:0]        ma;
        logic [26:0]        mb;
        logic [26:0]        m;
        logic               sr;
        logic signed [10:0] ew;
        logic               stk;
        logic [4:0]         cnt;
        logic [15:0]        tmr;
    } spfu_work_t;
endpackage
`default_nettype wire

//--- logic/spfu_top.sv
/*
 * Single precision floating add, subtract, multiply and divide unit.
 * Assumes the host presents both operands with a one-cycle start at an instruction
 * boundary and keeps bus arbitration; the unit only answers with grants.
 */
`timescale 1ns/1ps
`default_nettype none
`include "spfu_params.svh"
module spfu_top
    import spfu_pkg::*;
#(
    parameter int ADD_CYC   = `SPFU_CYC_UP(`SPFU_T_ADD_NS),
    parameter int SUB_CYC   = `SPFU_CYC_UP(`SPFU_T_SUB_NS),
    parameter int MUL_CYC   = `SPFU_CYC_UP(`SPFU_T_MUL_NS),
    parameter int DIV_CYC   = `SPFU_CYC_UP(`SPFU_T_DIV_NS),
    parameter int ALIGN_CYC = `SPFU_CYC_UP(`SPFU_T_ALIGN_NS),
    parameter int NORM_CYC  = `SPFU_CYC_UP(`SPFU_T_NORM_NS),
    parameter int ABORT_CYC = `SPFU_CYC_DN(`SPFU_T_ABORT_NS)
) (
    input  wire logic      core_clk,
    input  wire logic      srst,
    input  wire logic      clk_en,
    input  wire logic      start,
    input  wire spfu_req_t req,
    input  wire logic      bus_interrupt_request,
    input  wire logic      direct_transfer_request,
    output var  logic      busy_q,
    output var  logic      done_q,
    output var  logic      aborted_q,
    output var  spfu_rsp_t rsp_q,
    output var  logic [15:0] next_pc_q,
    output var  logic      irq_grant_q,
    output var  logic      dma_grant_q
);
    if (ADD_CYC < 64 || SUB_CYC < 64 || MUL_CYC < 64 || DIV_CYC < 64 ||
        ADD_CYC > 40000 || SUB_CYC > 40000 || MUL_CYC > 40000 || DIV_CYC > 40000 ||
        ALIGN_CYC < 1 || ALIGN_CYC > 64 || NORM_CYC < 1 || NORM_CYC > 256 ||
        ABORT_CYC < 1 || ABORT_CYC > 40000) begin : g_bad_cfg
        $error("spfu_top: cycle count parameters out of range");
    end

    // Counts narrowed to the width of the budget counter; the range check keeps them exact.
    localparam logic [15:0] ABORT16 = 16'(ABORT_CYC);
    localparam logic [15:0] ALIGN16 = 16'(ALIGN_CYC);
    localparam logic [15:0] NORM16  = 16'(NORM_CYC);

    spfu_work_t w_q;
    spfu_work_t w_d;

    // Operand unpacking; a zero exponent forces a zero fraction.
    logic [7:0]  a_exp;
    logic [7:0]  b_exp;
    logic        za;
    logic        zb;
    logic [26:0] a_man;
    logic [26:0] b_man;
    assign a_exp = req.a[`SPFU_EXP_HI:`SPFU_EXP_LO];
    assign b_exp = req.b[`SPFU_EXP_HI:`SPFU_EXP_LO];
    assign za    = (a_exp == 8'h00);
    assign zb    = (b_exp == 8'h00);
    assign a_man = za ? 27'h0 : {2'b01, req.a[22:0], 2'b00};
    assign b_man = zb ? 27'h0 : {2'b01, req.b[22:0], 2'b00};

    logic [15:0] base_cyc;
    assign base_cyc = (req.op == float_add_op)      ? 16'(ADD_CYC) :
                      (req.op == float_subtract_op) ? 16'(SUB_CYC) :
                      (req.op == float_multiply_op) ? 16'(MUL_CYC) : 16'(DIV_CYC);

    logic signed [10:0] ea_s;
    logic signed [10:0] eb_s;
    assign ea_s = $signed({3'h0, a_exp});
    assign eb_s = $signed({3'h0, b_exp});

    // Shared arithmetic on the working operands.
    logic        is_as;
    logic        sb_eff;
    logic        a_ge_b;
    logic [26:0] sum;
    logic [26:0] dif_ab;
    logic [26:0] dif_ba;
    logic [47:0] prod;
    assign is_as  = (w_q.op == float_add_op) || (w_q.op == float_subtract_op);
    assign sb_eff = w_q.sb ^ (w_q.op == float_subtract_op);
    assign a_ge_b = (w_q.ma >= w_q.mb);
    assign sum    = w_q.ma + w_q.mb;
    assign dif_ab = w_q.ma - w_q.mb;
    assign dif_ba = w_q.mb - w_q.ma;
    assign prod   = w_q.ma[25:2] * w_q.mb[25:2];

    logic [26:0] rem_nx;
    assign rem_nx = a_ge_b ? dif_ab : w_q.ma;

    // Rounding away from zero: any lost bit raises the magnitude by one unit.
    logic               inexact;
    logic [24:0]        rsum;
    logic signed [10:0] ew_fin;
    logic [22:0]        frac_fin;
    logic               r_zero;
    logic               r_ovf;
    logic               r_unf;
    spfu_rsp_t          rsp_fin;
    assign inexact  = w_q.stk | (|w_q.m[1:0]);
    assign rsum     = {1'b0, w_q.m[25:2]} + {24'h0, inexact};
    assign ew_fin   = w_q.ew + $signed({10'h0, rsum[24]});
    assign frac_fin = rsum[24] ? 23'h0 : rsum[22:0];
    assign r_zero   = (w_q.m == 27'h0) || w_q.dz;
    assign r_ovf    = !r_zero && (ew_fin > `SPFU_EXP_MAX);
    assign r_unf    = !r_zero && (ew_fin < 11'sh001);
    assign rsp_fin.word = (r_zero || r_ovf || r_unf) ? 32'h0 :
                          {w_q.sr, ew_fin[7:0], frac_fin};
    assign rsp_fin.ovf  = r_ovf;
    assign rsp_fin.unf  = r_unf;
    assign rsp_fin.dvz  = w_q.dz;

    // The budget counter holds the cycles left; a bus request while more than the abort
    // budget remains abandons the instruction so that the host can fetch it again.
    logic [15:0] tmr_dec;
    logic        busy_st;
    logic        far_br;
    logic        fin;
    assign tmr_dec = w_q.tmr - {15'h0, (w_q.tmr != 16'h0)};
    assign busy_st = (w_q.st != st_idle);
    assign far_br  = busy_st && bus_interrupt_request && (w_q.tmr > ABORT16);
    assign fin     = (w_q.st == st_pad) && (w_q.tmr == 16'h0);

    always_comb begin
        w_d     = w_q;
        w_d.tmr = tmr_dec;
        unique case (w_q.st)
            st_idle: begin
                if (start) begin
                    w_d.op  = req.op;
                    w_d.pc  = req.pc;
                    w_d.sa  = req.a[`SPFU_SIGN_BIT];
                    w_d.sb  = req.b[`SPFU_SIGN_BIT];
                    w_d.dz  = zb && (req.op == float_divide_op);
                    w_d.ea  = za ? b_exp : a_exp;
                    w_d.eb  = zb ? a_exp : b_exp;
                    w_d.ma  = a_man;
                    w_d.mb  = b_man;
                    w_d.m   = 27'h0;
                    w_d.stk = 1'b0;
                    w_d.sr  = req.a[`SPFU_SIGN_BIT] ^ req.b[`SPFU_SIGN_BIT];
                    w_d.cnt = (req.op == float_divide_op) ? `SPFU_DIV_STEPS : 5'h0;
                    w_d.tmr = base_cyc;
                    w_d.ew  = (req.op == float_divide_op) ? ea_s - eb_s + `SPFU_EXP_BIAS :
                              ea_s + eb_s - `SPFU_EXP_BIAS;
                    w_d.st  = (req.op == float_multiply_op) ? st_comb :
                              (req.op == float_divide_op)   ? st_div  : st_align;
                end
            end
            st_align: begin
                if (w_q.ea == w_q.eb) begin
                    w_d.st = st_comb;
                end else begin
                    if (w_q.ea < w_q.eb) begin
                        w_d.stk = w_q.stk | w_q.ma[0];
                        w_d.ma  = {1'b0, w_q.ma[26:1]};
                        w_d.ea  = w_q.ea + 8'h01;
                    end else begin
                        w_d.stk = w_q.stk | w_q.mb[0];
                        w_d.mb  = {1'b0, w_q.mb[26:1]};
                        w_d.eb  = w_q.eb + 8'h01;
                    end
                    // The first alignment shift is covered by the base time.
                    if (w_q.cnt != 5'h0) begin
                        w_d.tmr = tmr_dec + ALIGN16;
                    end
                    w_d.cnt = 5'h1;
                end
            end
            st_comb: begin
                w_d.st = st_norm;
                if (is_as) begin
                    w_d.ew = $signed({3'h0, w_q.ea});
                    // Bits lost in alignment belong to the smaller operand, so the true
                    // difference lies just below the kept one; one unit less keeps rounding exact.
                    if (w_q.sa == sb_eff) begin
                        w_d.m  = sum;
                        w_d.sr = w_q.sa;
                    end else if (a_ge_b) begin
                        w_d.m  = dif_ab - {26'h0, w_q.stk};
                        w_d.sr = w_q.sa;
                    end else begin
                        w_d.m  = dif_ba - {26'h0, w_q.stk};
                        w_d.sr = sb_eff;
                    end
                end else begin
                    w_d.m   = {1'b0, prod[47:22]};
                    w_d.stk = |prod[21:0];
                end
            end
            st_div: begin
                w_d.m   = {w_q.m[25:0], a_ge_b};
                w_d.ma  = {rem_nx[25:0], 1'b0};
                w_d.cnt = w_q.cnt - 5'h1;
                if (w_q.cnt == 5'h1) begin
                    w_d.stk = |rem_nx;
                    w_d.st  = st_norm;
                end
            end
            st_norm: begin
                if (w_q.m == 27'h0) begin
                    w_d.st = st_rnd;
                end else if (w_q.m[26]) begin
                    w_d.stk = w_q.stk | w_q.m[0];
                    w_d.m   = {1'b0, w_q.m[26:1]};
                    w_d.ew  = w_q.ew + 11'sh001;
                end else if (!w_q.m[25]) begin
                    w_d.m   = {w_q.m[25:0], 1'b0};
                    w_d.ew  = w_q.ew - 11'sh001;
                    w_d.tmr = tmr_dec + NORM16;
                end else begin
                    w_d.st = st_rnd;
                end
            end
            st_rnd: begin
                w_d.st = st_pad;
            end
            st_pad: begin
                // The rest of the budget is spent here so that each operation takes its full time.
                if (w_q.tmr == 16'h0) begin
                    w_d.st = st_idle;
                end
            end
        endcase
        if (far_br) begin
            w_d.st = st_idle;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            w_q         <= '0;
            w_q.st      <= st_idle;
            busy_q      <= 1'b0;
            done_q      <= 1'b0;
            aborted_q   <= 1'b0;
            rsp_q       <= '0;
            next_pc_q   <= 16'h0;
            irq_grant_q <= 1'b0;
            dma_grant_q <= 1'b0;
        end else if (clk_en) begin
            w_q         <= w_d;
            busy_q      <= (w_d.st != st_idle);
            done_q      <= fin;
            aborted_q   <= far_br;
            // Transfer grants follow their request in every state, so floating work adds no delay.
            dma_grant_q <= direct_transfer_request;
            // Interrupts wait for the idle state, which is the end of an instruction.
            irq_grant_q <= bus_interrupt_request && !busy_st && !start;
            // An instruction abandoned no later than its rounding step leaves the previous result in place.
            if ((w_q.st == st_rnd) && !far_br) begin
                rsp_q <= rsp_fin;
            end
            if (fin) begin
                next_pc_q <= w_q.pc + `SPFU_PC_STEP;
            end else if (far_br) begin
                next_pc_q <= w_q.pc;
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    logic [30:0] trunc_mag;
    assign trunc_mag = {w_q.ew[7:0], w_q.m[24:2]};

    sequence s_far_br;
        clk_en && far_br;
    endsequence
    sequence s_rnd_inexact;
        clk_en && !far_br && (w_q.st == st_rnd) && inexact && !r_zero && !rsum[24] &&
        (w_q.ew > 11'sh000) && (w_q.ew < `SPFU_EXP_MAX);
    endsequence

    a_abort_far_br: assert property (s_far_br |=> aborted_q && (w_q.st == st_idle))
        else $error("far bus request did not abort");
    a_abort_only_far: assert property ($rose(aborted_q) |-> $past(w_q.tmr) > ABORT16)
        else $error("abort with little work left");
    a_abort_keeps_pc: assert property (s_far_br |=> next_pc_q == $past(w_q.pc))
        else $error("abort moved the program counter");
    a_dma_not_held: assert property (clk_en && direct_transfer_request |=> dma_grant_q)
        else $error("transfer request delayed");
    a_irq_boundary: assert property ($rose(irq_grant_q) |-> !$past(busy_st))
        else $error("interrupt granted mid instruction");
    a_align_equal: assert property ((w_q.st == st_comb) && is_as |-> w_q.ea == w_q.eb)
        else $error("exponents not aligned");
    a_norm_top_bit: assert property ((w_q.st == st_rnd) |-> w_q.m[25] || (w_q.m == 27'h0))
        else $error("fraction not normalized");
    // The product exponent is held against the exponents of both operands.
    a_mul_exp_sum: assert property (clk_en && (w_q.st == st_comb) && !is_as &&
        (w_q.ma != 27'h0) && (w_q.mb != 27'h0) |=>
        (w_q.ew == $signed({3'h0, $past(w_q.ea)}) + $signed({3'h0, $past(w_q.eb)}) -
        `SPFU_EXP_BIAS) && (w_q.m == {1'b0, $past(prod[47:22])}))
        else $error("multiply exponent or fraction wrong");
    a_round_away: assert property (s_rnd_inexact |=> rsp_q.word[30:0] > $past(trunc_mag))
        else $error("rounding did not raise magnitude");
    a_zero_clean: assert property (done_q && (rsp_q.word[30:23] == 8'h00) |->
        rsp_q.word == 32'h0)
        else $error("zero result not clean");
endmodule
`default_nettype wire

//--- verif/spfu_host_model.sv
/*
 * Host side of the float unit: keeps the program counter and presents instructions.
 * Assumes the bench raises issue just after a falling edge, with operands already set.
 */
`timescale 1ns/1ps
`default_nettype none
module spfu_host_model
    import spfu_pkg::*;
#(
    parameter logic [15:0] START_PC = 16'h0200
) (
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic        issue,
    input  wire spfu_op_t    op,
    input  wire logic [31:0] a,
    input  wire logic [31:0] b,
    input  wire logic        done_q,
    input  wire logic        aborted_q,
    input  wire logic [15:0] next_pc_q,
    output logic             start,
    output spfu_req_t        req,
    output logic [15:0]      pc_q
);
    assign start = issue;
    assign req   = '{op: op, pc: pc_q, a: a, b: b};
    // An abandoned instruction is fetched again from the same address.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pc_q <= START_PC;
        end else if (done_q || aborted_q) begin
            pc_q <= next_pc_q;
        end
    end
endmodule
`default_nettype wire

//--- verif/testbench.sv
/*
 * Self-checking bench of the float unit with random and corner operands.
 * Assumes the unit is built with short counts and the host model beside it.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import spfu_pkg::*;
    localparam int          AL = 2;
    localparam int          NO = 2;
    localparam int          BASE [4] = '{64, 70, 80, 100};
    localparam logic [1:0]  C_OP [12] = '{0, 0, 1, 0, 1, 2, 2, 2, 3, 3, 1, 3};
    localparam logic [31:0] C_A [12] = '{32'h40000000, 32'h40400000, 32'h40400000,
        32'h007fffff, 32'h40000001, 32'hc0000001, 32'h7f800000, 32'h00800000,
        32'h40400000, 32'hc0400000, 32'h3f800000, 32'h40000000};
    localparam logic [31:0] C_B [12] = '{32'h40000000, 32'h3fc00000, 32'h40400000,
        32'h40400000, 32'h3a000001, 32'h40000001, 32'h7f800000, 32'h00800000,
        32'h00000000, 32'h40000000, 32'h40000000, 32'h40400000};
    logic        core_clk = 0, srst = 1, clk_en = 1, issue = 0, irq_want = 0, exp_dma = 0;
    logic        bus_interrupt_request = 0, direct_transfer_request = 0;
    logic        start, busy_q, done_q, aborted_q, irq_grant_q, dma_grant_q;
    logic [31:0] a_r = 0, b_r = 0;
    logic [15:0] next_pc_q, pc_q;
    spfu_op_t    op_r = float_add_op;
    spfu_req_t   req;
    spfu_rsp_t   rsp_q;
    int          n_errors = 0, checked = 0;

    spfu_top #(.ADD_CYC(BASE[0]), .SUB_CYC(BASE[1]), .MUL_CYC(BASE[2]), .DIV_CYC(BASE[3]),
        .ALIGN_CYC(AL), .NORM_CYC(NO), .ABORT_CYC(20)) i_spfu_top (.core_clk, .srst,
        .clk_en, .start, .req, .bus_interrupt_request, .direct_transfer_request, .busy_q,
        .done_q, .aborted_q, .rsp_q, .next_pc_q, .irq_grant_q, .dma_grant_q);
    spfu_host_model i_spfu_host_model (.core_clk, .srst, .issue, .op(op_r), .a(a_r),
        .b(b_r), .done_q, .aborted_q, .next_pc_q, .start, .req, .pc_q);

    always #5 core_clk = ~core_clk;

    task automatic check(input logic [63:0] seen, input logic [63:0] want, input string what);
        checked++;
        if (seen !== want) begin
            n_errors++;
            $display("BAD %0t %s seen %h want %h", $time, what, seen, want);
        end
    endtask

    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Exact value, then one rounding step away from zero on the 24-bit fraction.
    function automatic void fmodel(input logic [1:0] op, input logic [31:0] a, b,
        output logic [31:0] w, output logic [2:0] fl, output int ns, output int al);
        logic [127:0] m, x, y;
        int           e, ea, eb;
        logic         s, sb, za, zb;
        logic [24:0]  f;
        w = 0; fl = 0; ns = 0; al = 0; m = 0; e = 0; s = 0;
        za = a[30:23] == 0; zb = b[30:23] == 0;
        ea = za ? b[30:23] : a[30:23];
        eb = zb ? ea : b[30:23];
        x = za ? 0 : {1'b1, a[22:0]};
        y = zb ? 0 : {1'b1, b[22:0]};
        sb = b[31] ^ (op == 2'h1);
        if (op[1]) begin
            s = a[31] ^ b[31];
            if (op == 2'h3 && zb) fl = 3'h1;
            if (za || zb) return;
            if (op == 2'h2) begin
                m = (x * y) << 14; e = ea + eb - 128;
            end else begin
                m = (x << 62) / y; m[0] = m[0] | ((x << 62) % y != 0); e = ea - eb + 128;
            end
        end else begin
            x = x << 38; y = y << 38;
            if (ea >= eb) y = y >> (ea - eb); else x = x >> (eb - ea);
            e = ea > eb ? ea : eb;
            if (!za && !zb && ea != eb) al = (ea > eb ? ea - eb : eb - ea) - 1;
            if (a[31] == sb) begin m = x + y; s = sb; end
            else if (x >= y) begin m = x - y; s = a[31]; end
            else begin m = y - x; s = sb; end
        end
        if (m == 0) return;
        if (m[62]) begin m = (m >> 1) | m[0]; e++; end
        while (!m[61]) begin m = m << 1; e--; ns++; end
        f = m[61:38] + (m[37:0] != 0);
        if (f[24]) begin f = f >> 1; e++; end
        if (e > 255) fl = 3'h4; else if (e < 1) fl = 3'h2;
        else w = {s, e[7:0], f[22:0]};
    endfunction

    task automatic exec(input logic [1:0] op, input logic [31:0] a, b, input int irq_at,
        input bit ab);
        logic [31:0] w;
        logic [2:0]  fl;
        int          ns, al, n;
        spfu_rsp_t   old;
        logic [15:0] pc0;
        fmodel(op, a, b, w, fl, ns, al);
        // The host takes the new address one edge after the unit finishes.
        @(negedge core_clk);
        @(negedge core_clk);
        old = rsp_q;
        pc0 = pc_q;
        op_r <= spfu_op_t'(op); a_r <= a; b_r <= b; issue <= 1;
        n = 0;
        do begin @(posedge core_clk); #1; n++; end while (busy_q !== 1'b1 && n < 50);
        check(busy_q, 1, "taken");
        @(negedge core_clk) issue <= 0;
        n = 0;
        for (int k = 0; k < 6000; k++) begin
            @(posedge core_clk);
            if (clk_en) n++;
            if (n == irq_at) irq_want = 1;
            #1;
            if (done_q === 1'b1 || aborted_q === 1'b1) break;
            check(irq_grant_q, 0, "grant while busy");
        end
        irq_want = 0;
        check(aborted_q, ab, "abort");
        if (ab) begin
            check(next_pc_q, pc0, "pc kept");
            check(rsp_q, old, "result kept");
        end else begin
            check(rsp_q, {w, fl}, "result");
            check(next_pc_q, pc0 + 16'h0002, "pc step");
            if (w != 0) check(n, BASE[op] + AL * al + NO * ns + 1, "time");
        end
    endtask

    // Transfer requests toggle at random throughout; the grant must never wait.
    always @(negedge core_clk) begin
        if (srst) exp_dma = 0;
        else if (clk_en) exp_dma = direct_transfer_request;
        check(dma_grant_q, exp_dma, "transfer grant");
        clk_en <= srst || ($urandom % 8 != 0);
        direct_transfer_request <= $urandom % 2;
        bus_interrupt_request <= irq_want;
    end

    initial begin
        #600000;
        n_errors++;
        $display("BAD %0t watchdog expired", $time);
        report_and_stop;
    end

    initial begin
        logic [1:0]  op;
        int          ea, eb;
        bit          got;
        void'($urandom(10729));
        repeat (8) @(negedge core_clk);
        srst <= 0;
        for (int i = 0; i < 12; i++) exec(C_OP[i], C_A[i], C_B[i], -1, 0);
        $display("test corners done");
        for (int i = 0; i < 40; i++) begin
            op = $urandom % 4;
            ea = op[1] ? 64 + $urandom % 128 : 20 + $urandom % 200;
            eb = op[1] ? 64 + $urandom % 128 : ea + $urandom % 25 - 12;
            exec(op, {1'($urandom), 8'(ea), 23'($urandom)},
                {1'($urandom), 8'(eb), 23'($urandom)}, -1, 0);
        end
        $display("test random done");
        exec(2'h0, 32'h40400000, 32'h3fc00000, 3, 1);
        exec(2'h0, 32'h40400000, 32'h3fc00000, -1, 0);
        $display("test abort done");
        exec(2'h2, 32'h40400000, 32'h3fc00000, BASE[2] - 5, 0);
        irq_want = 1;
        got = 0;
        repeat (6) begin @(posedge core_clk); #1; got |= irq_grant_q; end
        irq_want = 0;
        check(got, 1, "grant when idle");
        $display("test late request done");
        report_and_stop;
    end
endmodule
`default_nettype wire
